/* hdl/wobble_pkg.sv */
// Constants for the wobble, length and count block
// What this block does
// - Reference select: center or maximum frequency
// - Select 0: amplitude is center times percent
// - Select 1: amplitude is maximum times percent
// - Zero amplitude: output equals set frequency
// - Jump is amplitude times jump percent
// - Clamp output between lower and upper limit while amplitude is nonzero
// - Wobble period 0.1 to 3000 s
// - Rise ramp is period times rise percent
// - Fall ramp is period times remainder
// - Length is pulse count over pulses-per-meter
// - Length above target drives function 10
// - Function 28 input clears measured length
// - Final count drives function 8, halts
// - Intermediate count drives function 9
package wobble_pkg;
   localparam int unsigned CLK_HZ      = 40_000_000;
   localparam int unsigned TICK_NS     = 1_000_000;
   localparam int unsigned TICK_CYCLES = TICK_NS / (1_000_000_000 / CLK_HZ);
   localparam int unsigned DIV_STEPS   = 16;
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_AMP  = 8'h04;
   localparam logic [7:0] A_PER  = 8'h08;
   localparam logic [7:0] A_RISE = 8'h0c;
   localparam logic [7:0] A_FREQ = 8'h10;
   localparam logic [7:0] A_LIM  = 8'h14;
   localparam logic [7:0] A_OUTF = 8'h18;
   localparam logic [7:0] A_LSET = 8'h1c;
   localparam logic [7:0] A_PPM  = 8'h20;
   localparam logic [7:0] A_LACT = 8'h24;
   localparam logic [7:0] A_CSET = 8'h28;
   localparam logic [7:0] A_CDES = 8'h2c;
   localparam logic [7:0] A_CVAL = 8'h30;
   localparam logic [7:0] A_IST  = 8'h34;
   localparam logic [7:0] A_IMSK = 8'h38;
   localparam logic [7:0] A_IFN  = 8'h3c;
   localparam logic [7:0] A_OFN  = 8'h40;
   localparam int unsigned HI_POS = 16;
   localparam logic [15:0] RST_PER   = 16'h0064;
   localparam logic [15:0] RST_RISE  = 16'h01f4;
   localparam logic [15:0] RST_PPM   = 16'h03e8;
   localparam logic [15:0] RST_CNT   = 16'h03e8;
   localparam logic [15:0] RST_FREQ  = 16'h1388;
   localparam logic [15:0] MAX_PCT   = 16'h03e8;
   localparam logic [15:0] MAX_JUMP  = 16'h01f4;
   localparam logic [15:0] MAX_PER   = 16'h7530;
   localparam logic [7:0]  FN_CNT_IN = 8'h19;
   localparam logic [7:0]  FN_LEN_IN = 8'h1b;
   localparam logic [7:0]  FN_LEN_RS = 8'h1c;
   localparam logic [7:0]  FN_CNT_FN = 8'h08;
   localparam logic [7:0]  FN_CNT_MD = 8'h09;
   localparam logic [7:0]  FN_LEN_AR = 8'h0a;
   localparam logic [16:0] LEN_STEP  = 17'h0000a;
   typedef enum logic [1:0] {ST_RISE = 2'b01, ST_FALL = 2'b10} ramp_t;
endpackage

/* hdl/wobble_length_counter.sv */
// Wobble generator, length meter and pulse counter with APB registers
//
// The APB slave port and the placing of the registers were left to the implementer.
module wobble_length_counter #(
   parameter int unsigned TICK_CYCLES = wobble_pkg::TICK_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [3:0]  multi_function_input,
   output logic      [1:0]  multi_function_output,
   output logic      [15:0] out_freq,
   output logic             irq
);
   function automatic logic [15:0] clampu(input logic [15:0] v, lo, hi);
      clampu = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction
   function automatic logic any_fn(input logic [3:0] lv, input logic [31:0] map,
                                   input logic [7:0] code);
      any_fn = 1'b0;
      for (int i = 0; i < 4; i++) begin
         if (lv[i] && map[8*i +: 8] == code) begin
            any_fn = 1'b1;
         end
      end
   endfunction
   function automatic logic out_fn(input logic [7:0] code, input logic cf, cm, la);
      out_fn = (code == wobble_pkg::FN_CNT_FN) ? cf :
               (code == wobble_pkg::FN_CNT_MD) ? cm :
               (code == wobble_pkg::FN_LEN_AR) ? la : 1'b0;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   logic        ref_sel_q;
   logic [15:0] amp_q, jump_q, per_q, rise_q, cen_q, max_q, lo_q, hi_q;
   logic [15:0] lset_q, ppm_q, cset_q, cdes_q;
   logic [3:0]  ist_q, imsk_q;
   logic [31:0] ifn_q;
   logic [15:0] ofn_q;
   logic        wr, rd, hit, cnt_clr;
   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;
   always_comb begin
      unique case (paddr)
         wobble_pkg::A_CTRL, wobble_pkg::A_AMP, wobble_pkg::A_PER, wobble_pkg::A_RISE,
         wobble_pkg::A_FREQ, wobble_pkg::A_LIM, wobble_pkg::A_OUTF, wobble_pkg::A_LSET,
         wobble_pkg::A_PPM, wobble_pkg::A_LACT, wobble_pkg::A_CSET, wobble_pkg::A_CDES,
         wobble_pkg::A_CVAL, wobble_pkg::A_IST, wobble_pkg::A_IMSK, wobble_pkg::A_IFN,
         wobble_pkg::A_OFN: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end
   assign cnt_clr = wr && paddr == wobble_pkg::A_CTRL && pwdata[1];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ref_sel_q <= 1'b0;
         amp_q  <= '0;
         jump_q <= '0;
         per_q  <= wobble_pkg::RST_PER;
         rise_q <= wobble_pkg::RST_RISE;
         cen_q  <= wobble_pkg::RST_FREQ;
         max_q  <= wobble_pkg::RST_FREQ;
         lo_q   <= '0;
         hi_q   <= wobble_pkg::RST_FREQ;
         lset_q <= '0;
         ppm_q  <= wobble_pkg::RST_PPM;
         cset_q <= wobble_pkg::RST_CNT;
         cdes_q <= wobble_pkg::RST_CNT;
         imsk_q <= '0;
         ifn_q  <= '0;
         ofn_q  <= '0;
      end else if (wr) begin
         unique case (paddr)
            wobble_pkg::A_CTRL: ref_sel_q <= pwdata[0];
            wobble_pkg::A_AMP: begin
               amp_q  <= pwdata[15:0];
               jump_q <= pwdata[31:16];
            end
            wobble_pkg::A_PER:  per_q  <= pwdata[15:0];
            wobble_pkg::A_RISE: rise_q <= pwdata[15:0];
            wobble_pkg::A_FREQ: begin
               cen_q <= pwdata[15:0];
               max_q <= pwdata[31:16];
            end
            wobble_pkg::A_LIM: begin
               lo_q <= pwdata[15:0];
               hi_q <= pwdata[31:16];
            end
            wobble_pkg::A_LSET: lset_q <= pwdata[15:0];
            wobble_pkg::A_PPM:  ppm_q  <= pwdata[15:0];
            wobble_pkg::A_CSET: cset_q <= pwdata[15:0];
            wobble_pkg::A_CDES: cdes_q <= pwdata[15:0];
            wobble_pkg::A_IMSK: imsk_q <= pwdata[3:0];
            wobble_pkg::A_IFN:  ifn_q  <= pwdata;
            wobble_pkg::A_OFN:  ofn_q  <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pins cross from the terminal side through two flops
   logic [3:0] mfi_s1_q, mfi_s2_q, mfi_s3_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mfi_s1_q <= '0;
         mfi_s2_q <= '0;
         mfi_s3_q <= '0;
      end else begin
         mfi_s1_q <= multi_function_input;
         mfi_s2_q <= mfi_s1_q;
         mfi_s3_q <= mfi_s2_q;
      end
   end
   logic [3:0] mfi_rise;
   logic       len_pulse, cnt_pulse, len_rst;
   assign mfi_rise  = mfi_s2_q & ~mfi_s3_q;
   assign len_pulse = any_fn(mfi_rise, ifn_q, wobble_pkg::FN_LEN_IN);
   assign cnt_pulse = any_fn(mfi_rise, ifn_q, wobble_pkg::FN_CNT_IN);
   assign len_rst   = any_fn(mfi_s2_q, ifn_q, wobble_pkg::FN_LEN_RS);

   ////////////////////////////////////////////////////////////////////////////////
   // Settings clamped to their legal spans
   logic [15:0] amp_e, jump_e, per_e, rise_e, ppm_e, base;
   logic [25:0] aw_prod, jp_prod;
   logic [15:0] aw, jmp;
   logic [21:0] full_ms, rise_ms, fall_ms, dur;
   logic [25:0] rise_prod;
   assign amp_e  = clampu(amp_q, 16'h0000, wobble_pkg::MAX_PCT);
   assign jump_e = clampu(jump_q, 16'h0000, wobble_pkg::MAX_JUMP);
   assign per_e  = clampu(per_q, 16'h0001, wobble_pkg::MAX_PER);
   assign rise_e = clampu(rise_q, 16'h0001, wobble_pkg::MAX_PCT);
   assign ppm_e  = clampu(ppm_q, 16'h0001, 16'hffff);
   assign base    = ref_sel_q ? max_q : cen_q;
   assign aw_prod = base * amp_e[9:0];
   assign aw      = 16'(aw_prod / 26'd1000);
   assign jp_prod = aw * jump_e[9:0];
   assign jmp     = 16'(jp_prod / 26'd1000);
   assign full_ms   = 22'(per_e) * 22'd100;
   assign rise_prod = per_e[14:0] * rise_e[10:0];
   assign rise_ms   = clampu22(22'(rise_prod / 26'd10));
   assign fall_ms   = full_ms - rise_ms;
   function automatic logic [21:0] clamp22(input logic [21:0] v);
      clamp22 = (v == '0) ? 22'h000001 : v;
   endfunction
   function automatic logic [21:0] clampu22(input logic [21:0] v);
      clampu22 = clamp22(v);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Millisecond tick and ramp phase
   logic [31:0]       tick_cnt_q;
   logic              tick, cyc_done;
   logic [21:0]       t_q;
   wobble_pkg::ramp_t st_q;
   assign tick = tick_cnt_q == TICK_CYCLES - 1;
   assign dur  = (st_q == wobble_pkg::ST_FALL) ? fall_ms : rise_ms;
   assign cyc_done = tick && st_q == wobble_pkg::ST_FALL && t_q + 22'd1 >= fall_ms;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_cnt_q <= '0;
      end else begin
         tick_cnt_q <= tick ? '0 : tick_cnt_q + 32'd1;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= wobble_pkg::ST_RISE;
         t_q  <= '0;
      end else if (tick) begin
         unique case (st_q)
            wobble_pkg::ST_RISE: begin
               if (t_q + 22'd1 >= rise_ms) begin
                  t_q <= '0;
                  if (fall_ms != '0) begin
                     st_q <= wobble_pkg::ST_FALL;
                  end
               end else begin
                  t_q <= t_q + 22'd1;
               end
            end
            wobble_pkg::ST_FALL: begin
               if (t_q + 22'd1 >= fall_ms) begin
                  t_q  <= '0;
                  st_q <= wobble_pkg::ST_RISE;
               end else begin
                  t_q <= t_q + 22'd1;
               end
            end
            default: begin
               st_q <= wobble_pkg::ST_RISE;
               t_q  <= '0;
            end
         endcase
      end
   end

   // Serial divider gives the ramp fraction t/dur; sixteen cycles per tick keeps it small
   logic        div_go_q, busy_q;
   logic [4:0]  dcnt_q;
   logic [22:0] rem_q, rem2;
   logic [15:0] quo_q, frac_q;
   logic        qbit;
   assign rem2 = {rem_q[21:0], 1'b0};
   assign qbit = rem2 >= {1'b0, dur};
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div_go_q <= 1'b0;
         busy_q   <= 1'b0;
         dcnt_q   <= '0;
         rem_q    <= '0;
         quo_q    <= '0;
         frac_q   <= '0;
      end else begin
         div_go_q <= tick;
         if (div_go_q) begin
            busy_q <= 1'b1;
            dcnt_q <= '0;
            rem_q  <= {1'b0, t_q};
         end else if (busy_q) begin
            rem_q  <= qbit ? rem2 - {1'b0, dur} : rem2;
            quo_q  <= {quo_q[14:0], qbit};
            dcnt_q <= dcnt_q + 5'd1;
            if (dcnt_q == 5'(wobble_pkg::DIV_STEPS - 1)) begin
               busy_q <= 1'b0;
               frac_q <= {quo_q[14:0], qbit};
            end
         end
         // A new ramp starts at zero; the old fraction would spike the output
         if (tick && t_q + 22'd1 >= dur) begin
            frac_q <= '0;
         end
      end
   end

   // Triangle from -aw+jump up to +aw, then from +aw-jump down to -aw
   logic [16:0]        span;
   logic [32:0]        dprod;
   logic signed [19:0] off, fsum;
   logic [15:0]        fout;
   assign span  = {aw, 1'b0} - {1'b0, jmp};
   assign dprod = span * frac_q;
   always_comb begin
      if (st_q == wobble_pkg::ST_RISE) begin
         off = -$signed({4'h0, aw}) + $signed({4'h0, jmp}) + $signed({3'h0, dprod[32:16]});
      end else begin
         off = $signed({4'h0, aw}) - $signed({4'h0, jmp}) - $signed({3'h0, dprod[32:16]});
      end
      fsum = $signed({4'h0, cen_q}) + off;
      if (fsum < $signed({4'h0, lo_q})) begin
         fout = lo_q;
      end else if (fsum > $signed({4'h0, hi_q})) begin
         fout = hi_q;
      end else begin
         fout = fsum[15:0];
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         out_freq <= '0;
      end else begin
         out_freq <= (amp_e == '0) ? cen_q : fout;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Length: each pulse adds ten tenths; one ppm drained per cycle bounds the pulse rate
   logic [16:0] acc_q;
   logic [15:0] len_q, cnt_q;
   logic        acc_ge, len_ar_q, cfin_q, cmid_q;
   assign acc_ge = acc_q >= {1'b0, ppm_e};
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc_q <= '0;
         len_q <= '0;
      end else if (len_rst) begin
         acc_q <= '0;
         len_q <= '0;
      end else begin
         acc_q <= acc_q - (acc_ge ? {1'b0, ppm_e} : 17'h00000)
                  + (len_pulse ? wobble_pkg::LEN_STEP : 17'h00000);
         if (acc_ge && len_q != 16'hffff) begin
            len_q <= len_q + 16'd1;
         end
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
      end else if (cnt_clr) begin
         cnt_q <= '0;
      end else if (cnt_pulse && cnt_q < cset_q) begin
         cnt_q <= cnt_q + 16'd1;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         len_ar_q <= 1'b0;
         cfin_q   <= 1'b0;
         cmid_q   <= 1'b0;
         multi_function_output <= '0;
      end else begin
         len_ar_q <= len_q > lset_q;
         cfin_q   <= cnt_q >= cset_q;
         cmid_q   <= cnt_q >= cdes_q;
         for (int i = 0; i < 2; i++) begin
            multi_function_output[i] <= out_fn(ofn_q[8*i +: 8], cfin_q, cmid_q, len_ar_q);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sticky events; a new event beats a same-cycle clear
   logic [3:0] ev;
   logic [2:0] prev_q;
   assign ev = {cyc_done, {cmid_q, cfin_q, len_ar_q} & ~prev_q};
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev_q <= '0;
         ist_q  <= '0;
         irq    <= 1'b0;
      end else begin
         prev_q <= {cmid_q, cfin_q, len_ar_q};
         ist_q  <= (ist_q & ~((wr && paddr == wobble_pkg::A_IST) ? pwdata[3:0] : 4'h0)) | ev;
         irq    <= |(ist_q & imsk_q);
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata <= '0;
      end else if (rd) begin
         unique case (paddr)
            wobble_pkg::A_CTRL: prdata <= {31'h0, ref_sel_q};
            wobble_pkg::A_AMP:  prdata <= {jump_q, amp_q};
            wobble_pkg::A_PER:  prdata <= {16'h0, per_q};
            wobble_pkg::A_RISE: prdata <= {16'h0, rise_q};
            wobble_pkg::A_FREQ: prdata <= {max_q, cen_q};
            wobble_pkg::A_LIM:  prdata <= {hi_q, lo_q};
            wobble_pkg::A_OUTF: prdata <= {16'h0, out_freq};
            wobble_pkg::A_LSET: prdata <= {16'h0, lset_q};
            wobble_pkg::A_PPM:  prdata <= {16'h0, ppm_q};
            wobble_pkg::A_LACT: prdata <= {16'h0, len_q};
            wobble_pkg::A_CSET: prdata <= {16'h0, cset_q};
            wobble_pkg::A_CDES: prdata <= {16'h0, cdes_q};
            wobble_pkg::A_CVAL: prdata <= {16'h0, cnt_q};
            wobble_pkg::A_IST:  prdata <= {28'h0, ist_q};
            wobble_pkg::A_IMSK: prdata <= {28'h0, imsk_q};
            wobble_pkg::A_IFN:  prdata <= ifn_q;
            wobble_pkg::A_OFN:  prdata <= {16'h0, ofn_q};
            default:            prdata <= '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   no_wobble_a: assert property (amp_e == '0 |=> out_freq == $past(cen_q))
      else $error("zero amplitude did not pass the set frequency");
   freq_clamp_a: assert property (amp_e != '0 && lo_q <= hi_q |=>
      out_freq >= $past(lo_q) && out_freq <= $past(hi_q))
      else $error("output frequency outside limits");
   rise_end_a: assert property (tick && st_q == wobble_pkg::ST_RISE && t_q + 22'd1 >= rise_ms
      && fall_ms != '0 |=> st_q == wobble_pkg::ST_FALL && t_q == '0)
      else $error("rise ramp did not end on time");
   fall_end_a: assert property (cyc_done |=> st_q == wobble_pkg::ST_RISE && t_q == '0)
      else $error("fall ramp did not end on time");
   len_step_a: assert property (acc_ge && !len_rst && len_q != 16'hffff
      |=> len_q == $past(len_q) + 16'd1)
      else $error("length did not advance");
   len_arrive_a: assert property (len_q > lset_q |-> ##2 multi_function_output[0]
      || ofn_q[7:0] != wobble_pkg::FN_LEN_AR || !$stable(ofn_q))
      else $error("length arrival not driven");
   len_clear_a: assert property (len_rst |=> len_q == '0)
      else $error("length reset ignored");
   cnt_halt_a: assert property (cnt_q >= cset_q && !cnt_clr |=> cnt_q == $past(cnt_q))
      else $error("counter ran past final target");
   cnt_mid_a: assert property (cnt_q >= cdes_q |=> cmid_q)
      else $error("intermediate arrival missing");
   wob_cycle_c: cover property (cyc_done && amp_e != '0);
   len_hit_c: cover property (!len_ar_q ##1 len_ar_q);
   cnt_fin_c: cover property (cmid_q && !cfin_q ##[1:1000] cfin_q);
   irq_c: cover property (irq);
endmodule

/* sim/terminal_model.sv */
// Terminal model: pulse and level sources on the multi-function input pins
module terminal_model (
   input  wire logic       clk,
   output logic      [3:0] pins
);
   timeunit 1ns;
   timeprecision 1ps;

   ////////////////////////////////////////////////////////////////////////////////
   // Pins idle low; each pulse level is held 4 clocks, above the two-flop sampling need
   initial begin
      pins = 4'h0;
   end

   // Count and length pulses come as clean pulse trains
   task automatic pulse(input int idx, input int n);
      repeat (n) begin
         @(posedge clk);
         pins[idx] <= 1'b1;
         repeat (4) @(posedge clk);
         pins[idx] <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask

   // Level input such as the length clear terminal
   task automatic level(input int idx, input logic v);
      @(posedge clk);
      pins[idx] <= v;
      repeat (6) @(posedge clk);
   endtask
endmodule

/* sim/testbench.sv */
// Self-checking bench for the wobble, length and count block
module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct {logic [7:0] a; logic [31:0] rst_v; logic [31:0] wr_v; logic [31:0] back;} row_t;

   logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq, e;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   logic [3:0]  mfi;
   logic [1:0]  mfo;
   logic [15:0] out_freq;
   int          fail_count, n_checks;
   row_t        rows[10];

   ////////////////////////////////////////////////////////////////////////////////
   // Short wobble tick keeps a full triangle within a few thousand clocks
   wobble_length_counter #(.TICK_CYCLES(40)) i_wobble_length_counter (
      .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .multi_function_input(mfi), .multi_function_output(mfo), .out_freq(out_freq), .irq(irq));

   terminal_model i_terminal_model (.clk(clk), .pins(mfi));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask

   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k;
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         fail_count++;
         test_done();
      end
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(a, 1'b0, 32'h0);
      check("register read", r, exp);
   endtask

   // Sequential length division has no fixed latency, so poll with a bound
   task automatic poll(input logic [7:0] a, input logic [31:0] exp);
      int k;
      k = 0;
      do begin
         apb(a, 1'b0, 32'h0);
         k++;
      end while (r !== exp && k < 60);
      check("polled register", r, exp);
   endtask

   task automatic span(input logic [15:0] hi, input logic [15:0] lo);
      logic [15:0] mx, mn;
      repeat (8) @(posedge clk);
      mx = 16'h0000;
      mn = 16'hffff;
      repeat (5000) begin
         @(posedge clk);
         if (out_freq > mx) mx = out_freq;
         if (out_freq < mn) mn = out_freq;
      end
      check("out_freq max", {16'h0, mx}, {16'h0, hi});
      check("out_freq min", {16'h0, mn}, {16'h0, lo});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
      fail_count = 0;
      n_checks = 0;
      rows = '{
         '{wobble_pkg::A_CTRL, 32'h0, 32'h0, 32'h0},
         '{wobble_pkg::A_AMP, 32'h0, 32'h025807d0, 32'h025807d0},
         '{wobble_pkg::A_PER, 32'h64, 32'h1, 32'h1},
         '{wobble_pkg::A_RISE, 32'h1f4, 32'h1f4, 32'h1f4},
         '{wobble_pkg::A_FREQ, 32'h13881388, 32'h138803e8, 32'h138803e8},
         '{wobble_pkg::A_LIM, 32'h13880000, 32'h13880000, 32'h13880000},
         '{wobble_pkg::A_LSET, 32'h0, 32'h2, 32'h2},
         '{wobble_pkg::A_PPM, 32'h3e8, 32'ha, 32'ha},
         '{wobble_pkg::A_CSET, 32'h3e8, 32'h3, 32'h3},
         '{wobble_pkg::A_CDES, 32'h3e8, 32'h2, 32'h2}};
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         rd_chk(rows[i].a, rows[i].rst_v);
         wr(rows[i].a, rows[i].wr_v);
         rd_chk(rows[i].a, rows[i].back);
      end
      // Count: input 0 counts, outputs show final and intermediate arrival
      wr(wobble_pkg::A_IMSK, 32'h4);
      wr(wobble_pkg::A_IFN, 32'h001c1b19);
      wr(wobble_pkg::A_OFN, 32'h00000908);
      i_terminal_model.pulse(0, 2);
      poll(wobble_pkg::A_CVAL, 32'h2);
      check("count outputs", {30'h0, mfo}, 32'h2);
      check("irq", {31'h0, irq}, 32'h1);
      i_terminal_model.pulse(0, 1);
      poll(wobble_pkg::A_CVAL, 32'h3);
      check("count outputs", {30'h0, mfo}, 32'h3);
      i_terminal_model.pulse(0, 2);
      rd_chk(wobble_pkg::A_CVAL, 32'h3);
      wr(wobble_pkg::A_IMSK, 32'h0);
      wr(wobble_pkg::A_IST, 32'hf);
      apb(wobble_pkg::A_IST, 1'b0, 32'h0);
      check("status cleared", r & 32'h7, 32'h0);
      check("masked irq", {31'h0, irq}, 32'h0);
      wr(wobble_pkg::A_CTRL, 32'h2);
      rd_chk(wobble_pkg::A_CVAL, 32'h0);
      // Length: arrival is strictly above target, clear terminal empties it
      wr(wobble_pkg::A_OFN, 32'h0000090a);
      i_terminal_model.pulse(1, 2);
      poll(wobble_pkg::A_LACT, 32'h2);
      rd_chk(wobble_pkg::A_LACT, 32'h2);
      check("length arrival", {31'h0, mfo[0]}, 32'h0);
      i_terminal_model.pulse(1, 1);
      poll(wobble_pkg::A_LACT, 32'h3);
      rd_chk(wobble_pkg::A_LACT, 32'h3);
      check("length arrival", {31'h0, mfo[0]}, 32'h1);
      i_terminal_model.level(2, 1'b1);
      poll(wobble_pkg::A_LACT, 32'h0);
      i_terminal_model.level(2, 1'b0);
      rd_chk(wobble_pkg::A_LACT, 32'h0);
      check("length arrival", {31'h0, mfo[0]}, 32'h0);
      // Unmapped address answers with an error and reads zero
      apb(8'h44, 1'b0, 32'h0);
      check("unmapped data", r, 32'h0);
      check("unmapped error", {31'h0, e}, 32'h1);
      // Wobble: 10 % of center 1000, then clamped, then relative to max 5000
      wr(wobble_pkg::A_AMP, 32'h00000064);
      span(16'h044c, 16'h0384);
      wr(wobble_pkg::A_LIM, 32'h041a03b6);
      span(16'h041a, 16'h03b6);
      // Full rise gives a sawtooth; its low end sits one jump above the bottom
      wr(wobble_pkg::A_RISE, 32'h3e8);
      wr(wobble_pkg::A_AMP, 32'h01f40064);
      wr(wobble_pkg::A_LIM, 32'h041a0000);
      repeat (60) @(posedge clk);
      span(16'h041a, 16'h03b6);
      wr(wobble_pkg::A_RISE, 32'h1f4);
      wr(wobble_pkg::A_AMP, 32'h00000064);
      wr(wobble_pkg::A_LIM, 32'h13880000);
      wr(wobble_pkg::A_CTRL, 32'h1);
      span(16'h05dc, 16'h01f4);
      wr(wobble_pkg::A_AMP, 32'h0);
      span(16'h03e8, 16'h03e8);
      rd_chk(wobble_pkg::A_OUTF, 32'h3e8);
      // Mid-run reset clears outputs and brings settings back
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      check("reset outputs", {out_freq, 13'h0, irq, mfo}, 32'h0);
      rst <= 1'b0;
      rd_chk(wobble_pkg::A_FREQ, 32'h13881388);
      rd_chk(wobble_pkg::A_LSET, 32'h0);
      test_done();
   end
endmodule
